// *** rtl/pemb_bank.sv ***
/*
  Error mask bank with master flag, first-error code and interrupt.
  Assumes error inputs are one-cycle or level pulses synchronous to sys_clk
  and a register master that never issues read and write together.
*/
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
module pemb_bank (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire pemb_pkg::pemb_err_t err_in,
  output logic error_flag,
  output logic irq
);
  logic [11:0] parity_mask_r;
  logic soft_mask_r, wdog_mask_r, stack_mask_r, loop_mask_r;
  logic clear_bit_r;
  logic flag_r;
  logic [15:0] code_r;
  logic [1:0] irq_stat_r, irq_mask_r;
  logic [15:0] reg_rdata_r;
  logic [15:0] rdata_nxt;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    return a == b;
  endfunction

  wire wr_parity = reg_wr && hit(reg_addr, pemb_pkg::ADDR_PARITY);
  wire wr_soft = reg_wr && hit(reg_addr, pemb_pkg::ADDR_SOFT);
  wire wr_wdog = reg_wr && hit(reg_addr, pemb_pkg::ADDR_WDOG);
  wire wr_stack = reg_wr && hit(reg_addr, pemb_pkg::ADDR_STACK);
  wire wr_loop = reg_wr && hit(reg_addr, pemb_pkg::ADDR_LOOP);
  wire wr_clear = reg_wr && hit(reg_addr, pemb_pkg::ADDR_CLEAR);
  wire wr_istat = reg_wr && hit(reg_addr, pemb_pkg::ADDR_IRQ_STAT);
  wire wr_imask = reg_wr && hit(reg_addr, pemb_pkg::ADDR_IRQ_MASK);

  // Bit order of the parity mask follows the struct: bank masks per memory
  wire [11:0] parity_err = err_in.parity;
  wire [11:0] parity_unmasked = parity_err & ~parity_mask_r;
  wire soft_ok = err_in.software & ~soft_mask_r;
  wire wdog_ok = err_in.watchdog & ~wdog_mask_r;
  wire stack_ok = err_in.stack_over & ~stack_mask_r;
  wire loop_ok = err_in.loop_over & ~loop_mask_r;
  wire [15:0] code_evt = {soft_ok, loop_ok, stack_ok, wdog_ok, parity_unmasked};
  wire any_err = |code_evt;
  // Clear acts only when the bit goes from 0 to 1
  wire clear_rise = wr_clear && reg_wdata[0] && !clear_bit_r;
  // A new error in the clear cycle is kept: set beats clear
  wire flag_nxt = any_err | (flag_r & ~clear_rise);
  wire code_take = any_err && (!flag_r || clear_rise);
  wire overlap_evt = any_err && flag_r && !clear_rise;
  wire [1:0] irq_evt = {overlap_evt, any_err && !flag_r};

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      parity_mask_r <= pemb_pkg::PARITY_RST;
      soft_mask_r <= 1'b0;
      wdog_mask_r <= 1'b0;
      stack_mask_r <= 1'b0;
      loop_mask_r <= 1'b0;
    end else begin
      if (wr_parity) parity_mask_r <= reg_wdata[11:0] & pemb_pkg::PARITY_WMASK;
      if (wr_soft) soft_mask_r <= reg_wdata[0];
      if (wr_wdog) wdog_mask_r <= reg_wdata[0];
      if (wr_stack) stack_mask_r <= reg_wdata[0];
      if (wr_loop) loop_mask_r <= reg_wdata[0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      clear_bit_r <= 1'b0;
      flag_r <= 1'b0;
      code_r <= 16'h0000;
    end else begin
      if (wr_clear) clear_bit_r <= reg_wdata[0];
      flag_r <= flag_nxt;
      if (code_take) code_r <= code_evt;
      else if (clear_rise) code_r <= 16'h0000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_stat_r <= 2'h0;
      irq_mask_r <= 2'h0;
    end else begin
      // Write-one-to-clear; a same-cycle event wins
      irq_stat_r <= (irq_stat_r & ~(wr_istat ? reg_wdata[1:0] : 2'h0)) | irq_evt;
      if (wr_imask) irq_mask_r <= reg_wdata[1:0];
    end
  end

  always_comb begin
    rdata_nxt = 16'h0000;
    unique case (reg_addr)
      pemb_pkg::ADDR_CLEAR: rdata_nxt = {15'h0000, clear_bit_r};
      pemb_pkg::ADDR_PARITY: rdata_nxt = {4'h0, parity_mask_r};
      pemb_pkg::ADDR_SOFT: rdata_nxt = {15'h0000, soft_mask_r};
      pemb_pkg::ADDR_WDOG: rdata_nxt = {15'h0000, wdog_mask_r};
      pemb_pkg::ADDR_STACK: rdata_nxt = {15'h0000, stack_mask_r};
      pemb_pkg::ADDR_LOOP: rdata_nxt = {15'h0000, loop_mask_r};
      pemb_pkg::ADDR_FLAG: rdata_nxt = {15'h0000, flag_r};
      pemb_pkg::ADDR_CODE: rdata_nxt = code_r;
      pemb_pkg::ADDR_IRQ_STAT: rdata_nxt = {14'h0000, irq_stat_r};
      pemb_pkg::ADDR_IRQ_MASK: rdata_nxt = {14'h0000, irq_mask_r};
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // Unmapped reads return zero; data held only one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (reset) reg_rdata_r <= 16'h0000;
    else reg_rdata_r <= reg_rd ? rdata_nxt : 16'h0000;
  end

  assign reg_rdata = reg_rdata_r;
  assign error_flag = flag_r;
  assign irq = |(irq_stat_r & irq_mask_r);

  masked_silent_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && !(|code_evt)) |=> !flag_r) else $error("flag set without unmasked error");
  flag_sticky_a: assert property (@(posedge sys_clk) disable iff (reset)
    (flag_r && !clear_rise) |=> flag_r) else $error("flag dropped without clear");
  flag_sets_a: assert property (@(posedge sys_clk) disable iff (reset)
    any_err |=> flag_r) else $error("flag not set by error");
  clear_edge_a: assert property (@(posedge sys_clk) disable iff (reset)
    (wr_clear && clear_bit_r && flag_r && !any_err) |=> flag_r) else $error("clear acted on level");
  first_code_a: assert property (@(posedge sys_clk) disable iff (reset)
    (flag_r && !clear_rise) |=> $stable(code_r)) else $error("code overwritten");
  parity_mask_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && (parity_err != 12'h000) && ((parity_err & ~parity_mask_r) == 12'h000) && !soft_ok
     && !wdog_ok && !stack_ok && !loop_ok) |=> !flag_r) else $error("masked parity reported");
  parity_reset_a: assert property (@(posedge sys_clk)
    reset |=> (parity_mask_r == 12'h003)) else $error("parity mask reset wrong");
  soft_code_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && soft_ok) |=> code_r[15]) else $error("software error not logged");

  // Per-source reporting: an unmasked error with the flag clear lands in its code bit

  data_b3_report_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && !parity_mask_r[11] && parity_err[11]) |=> (flag_r && code_r[11]))
    else $error("data memory b bank 3 not reported");

  data_b2_report_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && !parity_mask_r[10] && parity_err[10]) |=> (flag_r && code_r[10]))
    else $error("data memory b bank 2 not reported");

  data_b1_report_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && !parity_mask_r[9] && parity_err[9]) |=> (flag_r && code_r[9]))
    else $error("data memory b bank 1 not reported");

  data_b0_report_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && !parity_mask_r[8] && parity_err[8]) |=> (flag_r && code_r[8]))
    else $error("data memory b bank 0 not reported");

  data_a3_report_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && !parity_mask_r[7] && parity_err[7]) |=> (flag_r && code_r[7]))
    else $error("data memory a bank 3 not reported");

  data_a2_report_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && !parity_mask_r[6] && parity_err[6]) |=> (flag_r && code_r[6]))
    else $error("data memory a bank 2 not reported");

  data_a1_report_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && !parity_mask_r[5] && parity_err[5]) |=> (flag_r && code_r[5]))
    else $error("data memory a bank 1 not reported");

  data_a0_report_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && !parity_mask_r[4] && parity_err[4]) |=> (flag_r && code_r[4]))
    else $error("data memory a bank 0 not reported");

  prog_b_report_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && !parity_mask_r[3] && parity_err[3]) |=> (flag_r && code_r[3]))
    else $error("program memory b not reported");

  prog_a_report_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && !parity_mask_r[2] && parity_err[2]) |=> (flag_r && code_r[2]))
    else $error("program memory a not reported");

  conv_b_report_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && !parity_mask_r[1] && parity_err[1]) |=> (flag_r && code_r[1]))
    else $error("converter memory b not reported");

  conv_a_report_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && !parity_mask_r[0] && parity_err[0]) |=> (flag_r && code_r[0]))
    else $error("converter memory a not reported");

  // Masked sources: code bit stays clear because masked bits are dropped from code_evt

  data_b3_masked_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && parity_mask_r[11] && parity_err[11]) |=> !code_r[11])
    else $error("masked data memory b bank 3 logged");

  data_b2_masked_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && parity_mask_r[10] && parity_err[10]) |=> !code_r[10])
    else $error("masked data memory b bank 2 logged");

  data_b1_masked_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && parity_mask_r[9] && parity_err[9]) |=> !code_r[9])
    else $error("masked data memory b bank 1 logged");

  data_b0_masked_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && parity_mask_r[8] && parity_err[8]) |=> !code_r[8])
    else $error("masked data memory b bank 0 logged");

  data_a3_masked_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && parity_mask_r[7] && parity_err[7]) |=> !code_r[7])
    else $error("masked data memory a bank 3 logged");

  data_a2_masked_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && parity_mask_r[6] && parity_err[6]) |=> !code_r[6])
    else $error("masked data memory a bank 2 logged");

  data_a1_masked_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && parity_mask_r[5] && parity_err[5]) |=> !code_r[5])
    else $error("masked data memory a bank 1 logged");

  data_a0_masked_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && parity_mask_r[4] && parity_err[4]) |=> !code_r[4])
    else $error("masked data memory a bank 0 logged");

  prog_b_masked_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && parity_mask_r[3] && parity_err[3]) |=> !code_r[3])
    else $error("masked program memory b logged");

  prog_a_masked_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && parity_mask_r[2] && parity_err[2]) |=> !code_r[2])
    else $error("masked program memory a logged");

  conv_b_masked_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && parity_mask_r[1] && parity_err[1]) |=> !code_r[1])
    else $error("masked converter memory b logged");

  conv_a_masked_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && parity_mask_r[0] && parity_err[0]) |=> !code_r[0])
    else $error("masked converter memory a logged");

  // Single-bit sources

  soft_masked_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && soft_mask_r && err_in.software) |=> !code_r[pemb_pkg::CODE_SOFT])
    else $error("masked software error logged");

  wdog_report_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && wdog_ok) |=> (flag_r && code_r[pemb_pkg::CODE_WDOG]))
    else $error("watchdog error not logged");

  wdog_masked_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && wdog_mask_r && err_in.watchdog) |=> !code_r[pemb_pkg::CODE_WDOG])
    else $error("masked watchdog error logged");

  stack_report_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && stack_ok) |=> (flag_r && code_r[pemb_pkg::CODE_STACK]))
    else $error("stack error not logged");

  stack_masked_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && stack_mask_r && err_in.stack_over) |=> !code_r[pemb_pkg::CODE_STACK])
    else $error("masked stack error logged");

  loop_report_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && loop_ok) |=> (flag_r && code_r[pemb_pkg::CODE_LOOP]))
    else $error("loop error not logged");

  loop_masked_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && loop_mask_r && err_in.loop_over) |=> !code_r[pemb_pkg::CODE_LOOP])
    else $error("masked loop error logged");

  // Mask writes land at the strobe edge

  parity_write_a: assert property (@(posedge sys_clk) disable iff (reset)
    wr_parity |=> (parity_mask_r == $past(reg_wdata[11:0])))
    else $error("parity mask write lost");

  soft_write_a: assert property (@(posedge sys_clk) disable iff (reset)
    wr_soft |=> (soft_mask_r == $past(reg_wdata[0])))
    else $error("software mask write lost");

  wdog_write_a: assert property (@(posedge sys_clk) disable iff (reset)
    wr_wdog |=> (wdog_mask_r == $past(reg_wdata[0])))
    else $error("watchdog mask write lost");

  stack_write_a: assert property (@(posedge sys_clk) disable iff (reset)
    wr_stack |=> (stack_mask_r == $past(reg_wdata[0])))
    else $error("stack mask write lost");

  loop_write_a: assert property (@(posedge sys_clk) disable iff (reset)
    wr_loop |=> (loop_mask_r == $past(reg_wdata[0])))
    else $error("loop mask write lost");

  // Reset values of the single-bit masks

  soft_reset_a: assert property (@(posedge sys_clk)
    reset |=> !soft_mask_r)
    else $error("software mask reset wrong");

  wdog_reset_a: assert property (@(posedge sys_clk)
    reset |=> !wdog_mask_r)
    else $error("watchdog mask reset wrong");

  stack_reset_a: assert property (@(posedge sys_clk)
    reset |=> !stack_mask_r)
    else $error("stack mask reset wrong");

  loop_reset_a: assert property (@(posedge sys_clk)
    reset |=> !loop_mask_r)
    else $error("loop mask reset wrong");

  // Read port, clear sequencing, first code and irq status

  rsv_read_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
    (reg_rd && (reg_addr == pemb_pkg::ADDR_PARITY)) |=> (reg_rdata[15:12] == 4'h0))
    else $error("reserved parity bits read nonzero");

  parity_read_a: assert property (@(posedge sys_clk) disable iff (reset)
    (reg_rd && (reg_addr == pemb_pkg::ADDR_PARITY)) |=> (reg_rdata[11:0] == $past(parity_mask_r)))
    else $error("parity mask read wrong");

  rdata_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
    !reg_rd |=> (reg_rdata == 16'h0000))
    else $error("read data outside read slot");

  clear_drops_a: assert property (@(posedge sys_clk) disable iff (reset)
    (clear_rise && !any_err) |=> !flag_r)
    else $error("clear rise left flag set");

  clear_code_a: assert property (@(posedge sys_clk) disable iff (reset)
    (clear_rise && !any_err) |=> (code_r == 16'h0000))
    else $error("clear rise left code set");

  idle_code_a: assert property (@(posedge sys_clk) disable iff (reset)
    !flag_r |-> (code_r == 16'h0000))
    else $error("code set while flag clear");

  code_first_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!flag_r && any_err) |=> (code_r == $past(code_evt)))
    else $error("first error code wrong");

  clear_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    wr_clear |=> (clear_bit_r == $past(reg_wdata[0])))
    else $error("clear bit write lost");

  irq_first_a: assert property (@(posedge sys_clk) disable iff (reset)
    irq_evt[0] |=> irq_stat_r[0])
    else $error("first error status not set");

  irq_w1c_a: assert property (@(posedge sys_clk) disable iff (reset)
    (wr_istat && reg_wdata[0] && !irq_evt[0]) |=> !irq_stat_r[0])
    else $error("status bit not cleared");
endmodule // pemb_bank

// *** rtl/pemb_pkg.sv ***
/*
  Package for the error mask bank: register offsets, reset values,
  field positions and the packed carriers used by the bank.
  Assumes a 16-bit register port with one-cycle read latency.
*/
// Notes on behaviour
// - Second data memory bank masks at bits 11:8
// - First data memory bank masks at bits 7:4
// - Program memory masks at bits 3 and 2
// - Converter memory masks bits 1:0, reset set
// - Parity mask at f422, reset 0003, 15:12 reserved
// - Converters 0-3 bank a, 4-7 bank b
// - Each data memory bank separately maskable
// - Report only unmasked parity errors
// - Software error mask at f423 bit 0
// - Watchdog error mask at f424 bit 0
// - Stack error mask at f425 bit 0
// - Loop overrun mask at f426 bit 0
// - Sticky master flag on unmasked error
// - Clear acts on rising edge of bit
// - Code register latches first error only
package pemb_pkg;
  localparam logic [15:0] ADDR_CLEAR = 16'hf421;
  localparam logic [15:0] ADDR_PARITY = 16'hf422;
  localparam logic [15:0] ADDR_SOFT = 16'hf423;
  localparam logic [15:0] ADDR_WDOG = 16'hf424;
  localparam logic [15:0] ADDR_STACK = 16'hf425;
  localparam logic [15:0] ADDR_LOOP = 16'hf426;
  localparam logic [15:0] ADDR_FLAG = 16'hf427;
  localparam logic [15:0] ADDR_CODE = 16'hf428;
  localparam logic [15:0] ADDR_IRQ_STAT = 16'hf429;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'hf42a;
  localparam logic [11:0] PARITY_RST = 12'h003;
  localparam logic [11:0] PARITY_WMASK = 12'hfff;
  localparam int CODE_SOFT = 15;
  localparam int CODE_LOOP = 14;
  localparam int CODE_STACK = 13;
  localparam int CODE_WDOG = 12;
  localparam int IRQ_FLAG = 0;
  localparam int IRQ_OVERLAP = 1;

  // Parity sources in code-register order
  typedef struct packed {
    logic [3:0] data_mem_b_bank;
    logic [3:0] data_mem_a_bank;
    logic prog_mem_b;
    logic prog_mem_a;
    logic converter_mem_b;
    logic converter_mem_a;
  } pemb_parity_t;

  typedef struct packed {
    logic software;
    logic loop_over;
    logic stack_over;
    logic watchdog;
    pemb_parity_t parity;
  } pemb_err_t;
endpackage

// *** bench/pemb_bank_tb_top.sv ***
/*
  Self-checking bench for the error mask bank: map, masks, flag, code, irq.
  Assumes one-cycle read latency and synchronous active-high reset.
*/
`timescale 1ns/10ps
module pemb_bank_tb_top;
  logic sys_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, rd_q = 0, error_flag, irq;
  logic [15:0] reg_addr = '0, reg_wdata = '0, reg_rdata, v;
  logic [15:0] ua [4] = '{16'hf424, 16'hf425, 16'hf426, 16'hf423};
  logic [15:0] exp_q [$];
  pemb_pkg::pemb_err_t err_in = '0;
  int n_errors = 0, checks_done = 0;
  pemb_bank u_pemb_bank (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .err_in(err_in), .error_flag(error_flag), .irq(irq));
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  task chk(input logic [15:0] got, input logic [15:0] e);
    checks_done++;
    if (got !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task finish_test;
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Gap cycle after each strobe: no signal assigned twice in one step
  task wr(input logic [15:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rd(input logic [15:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  task er(input logic [15:0] d);
    err_in <= pemb_pkg::pemb_err_t'(d);
    @(posedge sys_clk);
    err_in <= '0;
    @(posedge sys_clk);
  endtask
  // Read data lives one cycle only, so sample it at the following edge
  always @(posedge sys_clk) begin
    if (rd_q) chk(reg_rdata, exp_q.pop_front());
    rd_q <= reg_rd;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    finish_test;
  end
  initial begin
    v = $urandom(32'h636e5edd);
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    rd(16'hf422, 16'h0003);
    for (int a = 16'hf423; a <= 16'hf426; a++) rd(a[15:0], 16'h0000);
    wr(16'hf430, 16'hffff);
    rd(16'hf430, 16'h0000);
    v = $urandom;
    wr(16'hf422, v);
    rd(16'hf422, v & 16'h0fff);
    wr(16'hf42a, 16'h0001);
    for (int i = 0; i < 16; i++) begin
      wr(16'hf422, 16'h0fff);
      for (int a = 16'hf423; a <= 16'hf426; a++) wr(a[15:0], 16'h0001);
      er(16'h0001 << i);
      chk({15'h0, error_flag}, 16'h0000);
      rd(16'hf428, 16'h0000);
      if (i < 12) wr(16'hf422, 16'h0fff ^ (16'h0001 << i));
      else wr(ua[i - 12], 16'h0000);
      er(16'hffff);
      chk({15'h0, error_flag}, 16'h0001);
      chk({15'h0, irq}, 16'h0001);
      rd(16'hf428, 16'h0001 << i);
      wr(16'hf422, 16'h0000);
      er(16'hffff);
      rd(16'hf428, 16'h0001 << i);
      rd(16'hf429, 16'h0003);
      wr(16'hf421, 16'h0001);
      rd(16'hf427, 16'h0000);
      er(16'h0001 << i);
      wr(16'hf421, 16'h0001);
      rd(16'hf421, 16'h0001);
      wr(16'hf421, 16'h0000);
      rd(16'hf427, 16'h0001);
      wr(16'hf421, 16'h0001);
      wr(16'hf421, 16'h0000);
      wr(16'hf429, 16'h0003);
      chk({15'h0, irq}, 16'h0000);
      rd(16'hf428, 16'h0000);
    end
    wr(16'hf42a, 16'h0000);
    er(16'h8000);
    chk({15'h0, irq}, 16'h0000);
    rd(16'hf429, 16'h0001);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rd(16'hf422, 16'h0003);
    rd(16'hf427, 16'h0000);
    @(posedge sys_clk);
    finish_test;
  end
endmodule // pemb_bank_tb_top
